/* oaps_ext_mem.sv */
// Model of the external memory side: counts bus-busy and dummy-read cycles.
// Assumes the scheduler's registered bus strobes and a bench-driven clear.
`timescale 1ns/1ns
module oaps_ext_mem (
  input  wire logic       core_clk,
  input  wire logic       clr,
  input  wire logic       ext_wr_q,
  input  wire logic       ext_dummy_q,
  output logic      [7:0] wr_clks,
  output logic      [7:0] dmy_clks
);
  // The model only answers by counting, since the scheduler carries no data.
  always_ff @(posedge core_clk) begin
    wr_clks  <= clr ? 8'h0 : wr_clks + {7'h0, ext_wr_q};
    dmy_clks <= clr ? 8'h0 : dmy_clks + {7'h0, ext_dummy_q};
  end
endmodule

/* oaps_phase_gen.sv */
// Minor phase generator: splits each major cycle into first and second half.
// Assumes one clock and a synchronised active-low reset.
`timescale 1ns/1ns
`include "oaps_regs.svh"
module oaps_phase_gen (
  input  wire logic core_clk,
  input  wire logic rst_sync_b,
  output logic      first_half_q,
  output logic      second_half_q,
  output logic      major_start
);
  logic [3:0] cnt_q;
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cnt_q         <= 4'h0;
      first_half_q  <= 1'b1;
      second_half_q <= 1'b0;
    end else if (cnt_q == 4'(`OAPS_MINOR_CYC - 1)) begin
      cnt_q         <= 4'h0;
      first_half_q  <= ~first_half_q;
      second_half_q <= first_half_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign major_start = second_half_q && (cnt_q == 4'(`OAPS_MINOR_CYC - 1));
endmodule

/* oaps_pkg.sv */
// Types for the operand access phase scheduler.
// Assumes nothing of its surroundings.
package oaps_pkg;
  typedef enum logic [3:0] {
    OAPS_CLS_NONE = 4'h1,
    OAPS_CLS_TRI  = 4'h2,
    OAPS_CLS_PST  = 4'h4,
    OAPS_CLS_PMA  = 4'h8
  } oaps_cls_t;
  typedef enum logic [5:0] {
    OAPS_ST_IDLE  = 6'h01,
    OAPS_ST_CYC1  = 6'h02,
    OAPS_ST_CYC2  = 6'h04,
    OAPS_ST_HOLD  = 6'h08,
    OAPS_ST_DUMMY = 6'h10,
    OAPS_ST_REAL  = 6'h20
  } oaps_state_t;
endpackage

/* oaps_regs.svh */
// Constants for the operand access phase scheduler: opcode fields and cycle counts.
// Assumes a single core clock; included by the package users by bare name.
`ifndef OAPS_REGS_SVH
`define OAPS_REGS_SVH
`define OAPS_OP3_HI        31
`define OAPS_OP3_LO        29
`define OAPS_OP3_CODE      3'h1
`define OAPS_PAR_HI        31
`define OAPS_PAR_LO        30
`define OAPS_PST_CODE      2'h3
`define OAPS_PMA_CODE      2'h2
`define OAPS_MAJOR_NS      60
`define OAPS_MINOR_NS      30
`define OAPS_CLK_NS        50
`define OAPS_MINOR_CYC     ((`OAPS_MINOR_NS + `OAPS_CLK_NS - 1) / `OAPS_CLK_NS)
`define OAPS_STORE_CYC     2
`define OAPS_DUMMY_CYC     2
`define OAPS_WORD_W        32
`define OAPS_ADDR_W        24
`endif

/* oaps_sched.sv */
// Operand access phase scheduler top: decodes the instruction class, sorts
// operands into internal or external, and paces reads and stores per phase.
// Assumes operand addresses and the external-store history come from the core.
// Operation
// - Top bits 001 mean three-operand read
// - Single internal source read in second half
// - Single external source spans whole cycle
// - Both internal: first then second half
// - Internal first, external second: one cycle
// - External first, internal second: two cycles
// - Both external: two cycles, one each
// - Dummy second read after external store
// - External read waits for store finish; the code holds only a three-operand read whose second source is external
// - Store two, dummy two, real one
// - Top bits 11 mean parallel store
// - Store second destination in second half
// - Reads in read stage, stores execute
// - Both stores internal: one cycle
// - External first store, internal second store
// - Internal first, external second: two bus
// - Both stores external: four bus cycles
// - Top bits 10 mean multiply-and-add
// - Both internal: third then fourth
// - Internal third, external fourth: one cycle
// - External third: fourth first, two cycles
// - Both external: third then fourth
// - Major cycle split into two halves
// - Fetch first half unless store pending
`timescale 1ns/1ns
`include "oaps_regs.svh"
module oaps_sched (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic                     instr_valid,
  input  wire logic [`OAPS_WORD_W-1:0]  instr_word,
  input  wire logic                     src_a_mem,
  input  wire logic                     src_b_mem,
  input  wire logic [`OAPS_ADDR_W-1:0]  addr_a,
  input  wire logic [`OAPS_ADDR_W-1:0]  addr_b,
  input  wire logic [`OAPS_ADDR_W-1:0]  int_base,
  input  wire logic [`OAPS_ADDR_W-1:0]  int_limit,
  input  wire logic                     store_ext_prev,
  output logic                          instr_ready_q,
  output logic                          stall_q,
  output logic                          first_half_q,
  output logic                          second_half_q,
  output logic                          int_rd_a_q,
  output logic                          int_rd_b_q,
  output logic                          int_wr_a_q,
  output logic                          int_wr_b_q,
  output logic                          ext_addr_a_q,
  output logic                          ext_addr_b_q,
  output logic                          ext_latch_q,
  output logic                          ext_wr_q,
  output logic                          ext_dummy_q,
  output logic                          fetch_first_q,
  output logic                          port_load_q
);
  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************************************
  // Phases
  // ****************************************************************
  logic fh;
  logic sh;
  logic major_start;
  oaps_phase_gen i_oaps_phase_gen (
    .core_clk      (core_clk),
    .rst_sync_b    (rst_sync_q),
    .first_half_q  (fh),
    .second_half_q (sh),
    .major_start   (major_start)
  );
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      first_half_q  <= 1'b0;
      second_half_q <= 1'b0;
    end else begin
      first_half_q  <= fh;
      second_half_q <= sh;
    end
  end

  // ****************************************************************
  // Decode
  // ****************************************************************
  oaps_pkg::oaps_cls_t cls;
  logic a_ext;
  logic b_ext;
  logic a_in_mem;
  logic b_in_mem;
  always_comb begin
    cls = oaps_pkg::OAPS_CLS_NONE;
    if (instr_word[`OAPS_OP3_HI:`OAPS_OP3_LO] == `OAPS_OP3_CODE) begin
      cls = oaps_pkg::OAPS_CLS_TRI;
    end else if (instr_word[`OAPS_PAR_HI:`OAPS_PAR_LO] == `OAPS_PST_CODE) begin
      cls = oaps_pkg::OAPS_CLS_PST;
    end else if (instr_word[`OAPS_PAR_HI:`OAPS_PAR_LO] == `OAPS_PMA_CODE) begin
      cls = oaps_pkg::OAPS_CLS_PMA;
    end
  end
  // Parallel forms always carry both operands in memory.
  assign a_in_mem = (cls == oaps_pkg::OAPS_CLS_TRI) ? src_a_mem : 1'b1;
  assign b_in_mem = (cls == oaps_pkg::OAPS_CLS_TRI) ? src_b_mem : 1'b1;
  assign a_ext = a_in_mem && ((addr_a < int_base) || (addr_a > int_limit));
  assign b_ext = b_in_mem && ((addr_b < int_base) || (addr_b > int_limit));

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  oaps_pkg::oaps_state_t st_q;
  oaps_pkg::oaps_cls_t   cls_q;
  logic                  a_ext_q;
  logic                  b_ext_q;
  logic                  a_mem_q;
  logic                  b_mem_q;
  logic [1:0]            cnt_q;
  logic                  take;
  logic                  tri_rd;
  assign tri_rd = a_in_mem || b_in_mem;
  assign take   = instr_valid && instr_ready_q && major_start;

  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      st_q    <= oaps_pkg::OAPS_ST_IDLE;
      cls_q   <= oaps_pkg::OAPS_CLS_NONE;
      a_ext_q <= 1'b0;
      b_ext_q <= 1'b0;
      a_mem_q <= 1'b0;
      b_mem_q <= 1'b0;
      cnt_q   <= 2'h0;
    end else begin
      unique case (st_q)
        oaps_pkg::OAPS_ST_IDLE: begin
          if (take && (cls != oaps_pkg::OAPS_CLS_NONE)
              && (cls != oaps_pkg::OAPS_CLS_TRI || tri_rd)) begin
            cls_q   <= cls;
            a_ext_q <= a_ext;
            b_ext_q <= b_ext;
            a_mem_q <= a_in_mem;
            b_mem_q <= b_in_mem;
            if (cls == oaps_pkg::OAPS_CLS_TRI && b_ext && store_ext_prev) begin
              st_q  <= oaps_pkg::OAPS_ST_HOLD;
              cnt_q <= 2'(`OAPS_STORE_CYC - 1);
            end else begin
              st_q <= oaps_pkg::OAPS_ST_CYC1;
            end
          end
        end
        oaps_pkg::OAPS_ST_CYC1: begin
          if (major_start) begin
            if (a_ext_q && (b_ext_q || b_mem_q) && a_mem_q && b_mem_q
                && cls_q != oaps_pkg::OAPS_CLS_PST) begin
              st_q <= oaps_pkg::OAPS_ST_CYC2;
            end else begin
              st_q <= oaps_pkg::OAPS_ST_IDLE;
            end
          end
        end
        oaps_pkg::OAPS_ST_CYC2: begin
          if (major_start) begin
            st_q <= oaps_pkg::OAPS_ST_IDLE;
          end
        end
        oaps_pkg::OAPS_ST_HOLD: begin
          if (major_start) begin
            if (cnt_q == 2'h0) begin
              st_q  <= oaps_pkg::OAPS_ST_DUMMY;
              cnt_q <= 2'(`OAPS_DUMMY_CYC - 1);
            end else begin
              cnt_q <= cnt_q - 2'h1;
            end
          end
        end
        oaps_pkg::OAPS_ST_DUMMY: begin
          if (major_start) begin
            if (cnt_q == 2'h0) begin
              st_q <= oaps_pkg::OAPS_ST_REAL;
            end else begin
              cnt_q <= cnt_q - 2'h1;
            end
          end
        end
        oaps_pkg::OAPS_ST_REAL: begin
          if (major_start) begin
            st_q <= a_ext_q ? oaps_pkg::OAPS_ST_CYC2 : oaps_pkg::OAPS_ST_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Strobes per phase
  // ****************************************************************
  logic c1;
  logic c2;
  logic tri_c;
  logic pst_c;
  logic pma_c;
  logic two_int;
  assign c1    = (st_q == oaps_pkg::OAPS_ST_CYC1) || (st_q == oaps_pkg::OAPS_ST_REAL);
  assign c2    = (st_q == oaps_pkg::OAPS_ST_CYC2);
  assign tri_c = (cls_q == oaps_pkg::OAPS_CLS_TRI);
  assign pst_c = (cls_q == oaps_pkg::OAPS_CLS_PST);
  assign pma_c = (cls_q == oaps_pkg::OAPS_CLS_PMA);
  assign two_int = a_mem_q && b_mem_q && !a_ext_q && !b_ext_q;

  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      int_rd_a_q   <= 1'b0;
      int_rd_b_q   <= 1'b0;
      ext_addr_a_q <= 1'b0;
      ext_addr_b_q <= 1'b0;
      ext_latch_q  <= 1'b0;
      ext_dummy_q  <= 1'b0;
    end else begin
      int_rd_a_q   <= 1'b0;
      int_rd_b_q   <= 1'b0;
      ext_addr_a_q <= 1'b0;
      ext_addr_b_q <= 1'b0;
      ext_latch_q  <= 1'b0;
      ext_dummy_q  <= (st_q == oaps_pkg::OAPS_ST_DUMMY);
      if ((tri_c || pma_c) && c1) begin
        if (a_mem_q != b_mem_q) begin
          int_rd_a_q <= a_mem_q && !a_ext_q && sh;
          int_rd_b_q <= b_mem_q && !b_ext_q && sh;
          ext_addr_a_q <= a_ext_q;
          ext_addr_b_q <= b_ext_q;
          ext_latch_q  <= (a_ext_q || b_ext_q) && major_start;
        end else if (two_int) begin
          int_rd_a_q <= fh;
          int_rd_b_q <= sh;
        end else if (!a_ext_q && b_ext_q) begin
          int_rd_a_q   <= fh;
          ext_addr_b_q <= 1'b1;
          ext_latch_q  <= major_start;
        end else if (a_ext_q && !b_ext_q && tri_c) begin
          ext_addr_a_q <= 1'b1;
          ext_latch_q  <= major_start;
        end else if (a_ext_q && !b_ext_q) begin
          int_rd_b_q <= sh;
        end else begin
          ext_addr_a_q <= 1'b1;
          ext_latch_q  <= major_start;
        end
      end else if ((tri_c || pma_c) && c2) begin
        if (!b_ext_q) begin
          // Three-operand: internal source finishes after the external word landed; multiply-and-add latches its external third here.
          int_rd_b_q   <= tri_c ? sh : 1'b0;
          ext_addr_a_q <= pma_c;
          ext_latch_q  <= pma_c && major_start;
        end else begin
          ext_addr_b_q <= 1'b1;
          ext_latch_q  <= major_start;
        end
      end else if (pst_c && c1) begin
        int_rd_a_q   <= !a_ext_q && sh;
        ext_addr_a_q <= a_ext_q;
        ext_latch_q  <= a_ext_q && major_start;
      end
    end
  end

  // ****************************************************************
  // Stores
  // ****************************************************************
  // Bus cycles left after cycle one: one for the first destination, two for the
  // second, since its port handoff pushes the bus store into the next cycle.
  logic [1:0] wr_left_q;
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      int_wr_a_q  <= 1'b0;
      int_wr_b_q  <= 1'b0;
      ext_wr_q    <= 1'b0;
      port_load_q <= 1'b0;
      wr_left_q   <= 2'h0;
    end else begin
      int_wr_a_q  <= 1'b0;
      int_wr_b_q  <= 1'b0;
      port_load_q <= 1'b0;
      if (major_start && wr_left_q != 2'h0) begin
        wr_left_q <= wr_left_q - 2'h1;
      end
      ext_wr_q <= (wr_left_q != 2'h0) || (pst_c && c1 && a_ext_q);
      if (pst_c && c1) begin
        int_wr_a_q <= !a_ext_q && fh;
        int_wr_b_q <= !b_ext_q && sh;
        if (major_start) begin
          wr_left_q <= {b_ext_q, a_ext_q};
        end
        port_load_q <= (a_ext_q && fh) || (b_ext_q && sh);
      end
    end
  end

  // ****************************************************************
  // Fetch placement and stall
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      fetch_first_q <= 1'b1;
      stall_q       <= 1'b0;
      instr_ready_q <= 1'b0;
    end else begin
      fetch_first_q <= !(pst_c && c1 && (a_ext_q != b_ext_q || !two_int));
      stall_q       <= (st_q == oaps_pkg::OAPS_ST_CYC2)
                    || (st_q == oaps_pkg::OAPS_ST_HOLD)
                    || (st_q == oaps_pkg::OAPS_ST_DUMMY);
      instr_ready_q <= (st_q == oaps_pkg::OAPS_ST_IDLE);
    end
  end
endmodule

/* oaps_sched_assertions.sv */
// Concurrent checks on the outputs of the operand access phase scheduler.
// Assumes it is bound to the scheduler top and sees only that module's ports.
`timescale 1ns/1ns
module oaps_sched_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic instr_ready_q,
  input wire logic stall_q,
  input wire logic first_half_q,
  input wire logic second_half_q,
  input wire logic int_rd_a_q,
  input wire logic int_rd_b_q,
  input wire logic int_wr_a_q,
  input wire logic int_wr_b_q,
  input wire logic ext_latch_q,
  input wire logic ext_wr_q,
  input wire logic ext_dummy_q
);
  // ****************************************
  // Phase and access relations
  // ****************************************
  default clocking chk_cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_halves_apart: assert property (!(first_half_q && second_half_q))
    else $error("both half phases high together");
  a_halves_alternate: assert property (first_half_q |=> second_half_q ##1 first_half_q)
    else $error("half phases do not alternate");
  a_latch_late_half: assert property (ext_latch_q |-> second_half_q)
    else $error("external latch outside the second half");
  a_latch_one_pulse: assert property (ext_latch_q |=> !ext_latch_q)
    else $error("external latch held longer than one cycle");
  a_src_reads_split: assert property (!(int_rd_a_q && int_rd_b_q))
    else $error("both internal source reads in one phase");
  a_second_source_late_half: assert property (int_rd_b_q |-> second_half_q)
    else $error("second source internal read outside the second half");
  a_second_destination_late_half: assert property (int_wr_b_q |-> second_half_q)
    else $error("second destination internal store outside the second half");
  a_dst_first_half: assert property (int_wr_a_q |-> first_half_q && !int_wr_b_q)
    else $error("first destination store not alone in first half");
  a_dummy_after_store: assert property (ext_dummy_q |-> !ext_wr_q)
    else $error("dummy read while the external store is busy");
  a_stall_not_idle: assert property (stall_q |-> !instr_ready_q)
    else $error("stall while the scheduler reports idle");

  c_dummy_read: cover property (ext_dummy_q);
  c_stall_cycle: cover property (stall_q);
  c_two_stores: cover property (int_wr_a_q ##1 int_wr_b_q);
endmodule

/* oaps_sched_bench.sv */
// Self-checking bench for the operand access phase scheduler.
// Assumes design, checker and external memory model are compiled before it.
`timescale 1ns/1ns
`include "oaps_regs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module oaps_sched_bench;
  logic                    core_clk = 1'b0;
  logic                    rst_b = 1'b0;
  logic                    instr_valid = 1'b0;
  logic [`OAPS_WORD_W-1:0] instr_word = 32'h0;
  logic                    src_a_mem = 1'b0;
  logic                    src_b_mem = 1'b0;
  logic [`OAPS_ADDR_W-1:0] addr_a = 24'h0;
  logic [`OAPS_ADDR_W-1:0] addr_b = 24'h0;
  logic [`OAPS_ADDR_W-1:0] int_base = 24'h001000;
  logic [`OAPS_ADDR_W-1:0] int_limit = 24'h001FFF;
  logic                    store_ext_prev = 1'b0;
  logic                    clr = 1'b1;
  logic instr_ready_q, stall_q, first_half_q, second_half_q, int_rd_a_q, int_rd_b_q;
  logic int_wr_a_q, int_wr_b_q, ext_addr_a_q, ext_addr_b_q, ext_latch_q, ext_wr_q;
  logic ext_dummy_q, fetch_first_q, port_load_q, stl, dmy;
  logic [1:0]              ra, rb, wa, wb, lat, ea, eb, pl, fm;
  logic [7:0]              wr_clks, dmy_clks;
  logic [31:0]             seed = 32'h4829;
  int                      failures = 0;
  int                      checks_done = 0;
  int                      k;

  always #(`OAPS_CLK_NS / 2) core_clk = ~core_clk;

  oaps_sched i_oaps_sched (.core_clk, .rst_b, .instr_valid, .instr_word, .src_a_mem,
    .src_b_mem, .addr_a, .addr_b, .int_base, .int_limit, .store_ext_prev, .instr_ready_q,
    .stall_q, .first_half_q, .second_half_q, .int_rd_a_q, .int_rd_b_q, .int_wr_a_q,
    .int_wr_b_q, .ext_addr_a_q, .ext_addr_b_q, .ext_latch_q, .ext_wr_q, .ext_dummy_q,
    .fetch_first_q, .port_load_q);
  oaps_ext_mem i_oaps_ext_mem (.core_clk, .clr, .ext_wr_q, .ext_dummy_q, .wr_clks,
    .dmy_clks);

  // ****************************************
  // Stimulus helpers and expectations
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // A first source held off chip costs a second cycle whenever both sources are in memory.
  function automatic logic [7:0] exp_rd(input logic ae, be, am, bm, sp);
    logic d;
    d = sp & bm & be;
    return {(am & ae & bm) | d, d, 2'(am & !ae), 2'(bm & !be),
            2'(am & ae) + 2'(bm & be)};
  endfunction

  task automatic tally();
    @(negedge core_clk);
    ra += {1'b0, int_rd_a_q};
    rb += {1'b0, int_rd_b_q};
    wa += {1'b0, int_wr_a_q};
    wb += {1'b0, int_wr_b_q};
    lat += {1'b0, ext_latch_q};
    ea += {1'b0, ext_addr_a_q};
    eb += {1'b0, ext_addr_b_q};
    pl += {1'b0, port_load_q};
    fm += {1'b0, !fetch_first_q};
    stl |= stall_q;
    dmy |= ext_dummy_q;
  endtask

  // Class 0 three-operand, 1 parallel store, 2 multiply-and-add, 3 a word to be ignored.
  task automatic run(input logic [1:0] cls, input logic ae, be, am, bm, sp);
    int n;
    seed = xs(seed);
    case (cls)
      2'h0: instr_word = {3'h1, seed[28:0]};
      2'h1: instr_word = {2'h3, seed[29:0]};
      2'h2: instr_word = {2'h2, seed[29:0]};
      default: instr_word = {3'h0, seed[28:0]};
    endcase
    addr_a = ae ? {8'h80, seed[15:0]} : {12'h001, seed[11:0]};
    addr_b = be ? {8'h81, seed[31:16]} : {12'h001, seed[23:12]};
    src_a_mem = am;
    src_b_mem = bm;
    store_ext_prev = sp;
    {ra, rb, wa, wb, lat, ea, eb, pl, fm, stl, dmy} = '0;
    clr = 1'b1;
    instr_valid = 1'b1;
    n = 0;
    while ((instr_valid || !instr_ready_q) && n < 60) begin
      tally();
      clr = 1'b0;
      n++;
      if (!instr_ready_q || n > 40)
        instr_valid = 1'b0;
    end
    // The external store tail outlasts the return to idle by up to three majors.
    repeat (8) tally();
    if (cls == 2'h1) begin
      `CHK({stl, wa, wb}, {1'b0, 2'(!ae), 2'(!be)})
      `CHK(wr_clks, 8'(4 * (ae + be)))
      `CHK({ea, eb, pl}, {ae, 1'b0, 2'h0, 2'(ae) + 2'(be)})
      `CHK(fm, {ae | be, 1'b0})
    end else begin
      `CHK({stl, dmy, ra, rb, lat}, exp_rd(ae, be, am, bm, sp))
      `CHK({ea, eb}, {am & ae, 1'b0, bm & be, 1'b0})
      `CHK(fm, 2'h0)
      if (sp & bm & be) `CHK(dmy_clks, 8'h4)
    end
    $display("test cls %0d ext %b%b mem %b%b prev %b done", cls, ae, be, am, bm, sp);
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    for (k = 0; k < 12; k++)
      run(2'(k / 4), k[1], k[0], 1'b1, 1'b1, 1'b0);
    for (k = 0; k < 4; k++)
      run(2'h0, k[1], k[1], !k[0], k[0], 1'b0);
    run(2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    run(2'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    run(2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    run(2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    for (k = 0; k < 24; k++) begin
      seed = xs(seed);
      if (seed[1:0] == 2'h0)
        run(2'h0, seed[2], seed[3], seed[4] | !seed[5], seed[5], seed[6]);
      else
        run(2'(seed[1]), seed[2], seed[3], 1'b1, 1'b1, 1'b0);
    end
    wrap_up();
  end

  initial begin
    #(`OAPS_CLK_NS * 8000);
    failures++;
    wrap_up();
  end
endmodule

bind oaps_sched oaps_sched_chk i_oaps_sched_chk (.core_clk, .rst_b, .instr_ready_q, .stall_q,
  .first_half_q, .second_half_q, .int_rd_a_q, .int_rd_b_q, .int_wr_a_q, .int_wr_b_q,
  .ext_latch_q, .ext_wr_q, .ext_dummy_q);
